// *** ref_ladder_ctrl.sv ***
// top of the comparator reference ladder control: AXI4-Lite slave and analog controls
// assumes aclk at 40 MHz; the ladder and comparators sit outside
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1: bit 15 enables the ladder; zero powers it down drawing no current.
// R2: changing the enable bit leaves every other control field unchanged.
// R3: bit 6 connects the reference to the output pin.
// R4: range bit one selects low range, tap times source over 24.
// R5: range bit zero gives quarter source plus tap times source over 32.
// R6: bit 4 picks external reference pins, zero picks analog supply rails.
// R7: bits 3 to 0 hold the tap value, sixteen codes.
// R8: unimplemented bits read zero and ignore writes.
// R9: offsets 0x4, 0x8, 0xC clear, set or invert bits written one.
// R10: every field resets to zero.
// R11: software avoids access in the cycle after clearing enable.
// R12: controls drive the ladder from registers, updated on the write edge; here they update one edge after the write changes the stored word.
module ref_ladder_ctrl
(
    input  wire logic               aclk,          // bus clock, 40 MHz
    input  wire logic               aresetn,       // synchronous reset, low
    input  wire logic [15:0]        s_axi_awaddr,  // write address
    input  wire logic [2:0]         s_axi_awprot,  // unused protection
    input  wire logic               s_axi_awvalid, // write address valid
    output logic                    s_axi_awready, // write address ready
    input  wire logic [31:0]        s_axi_wdata,   // write data
    input  wire logic [3:0]         s_axi_wstrb,   // byte strobes
    input  wire logic               s_axi_wvalid,  // write data valid
    output logic                    s_axi_wready,  // write data ready
    output logic [1:0]              s_axi_bresp,   // write response
    output logic                    s_axi_bvalid,  // write response valid
    input  wire logic               s_axi_bready,  // write response ready
    input  wire logic [15:0]        s_axi_araddr,  // read address
    input  wire logic [2:0]         s_axi_arprot,  // unused protection
    input  wire logic               s_axi_arvalid, // read address valid
    output logic                    s_axi_arready, // read address ready
    output logic [31:0]             s_axi_rdata,   // read data
    output logic [1:0]              s_axi_rresp,   // read response
    output logic                    s_axi_rvalid,  // read data valid
    input  wire logic               s_axi_rready,  // read data ready
    output ref_ladder_pkg::ladder_ctrl_t ladder_ctrl // controls to the analog ladder
);
    import ref_ladder_pkg::*;

    logic [15:0] awaddr_reg;
    logic        aw_held_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        w_held_reg;
    logic        wr_fire;
    logic        wr_hit;
    write_op_t   wr_op;
    logic [31:0] strb_mask;
    logic [31:0] ctrl_reg;
    logic        rd_hit;

    // returns true when the address falls in the control word or an alias
    function automatic logic addr_hit(input logic [15:0] a);
        addr_hit = (a[15:4] == CTRL_OFFSET[15:4]) && (a[1:0] == 2'b00);
    endfunction

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    // capture address and data independently, in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= 16'h0000;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_held_reg <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_held_reg <= 1'b0;
    end

    assign wr_fire   = aw_held_reg && w_held_reg;
    assign wr_hit    = addr_hit(awaddr_reg);
    assign strb_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

    // the low address bits pick the operation applied to the stored word
    always_comb
    begin
        case (awaddr_reg[3:0])
            CLR_ALIAS[3:0]: wr_op = OP_CLEAR; // [R9]
            SET_ALIAS[3:0]: wr_op = OP_SET;   // [R9]
            INV_ALIAS[3:0]: wr_op = OP_INV;   // [R9]
            default:        wr_op = OP_WRITE;
        endcase
    end

    ref_ladder_regfile ref_ladder_regfile_i
    (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .wr_en        (wr_fire && wr_hit),
        .wr_op        (wr_op),
        .wr_data      (wdata_reg),
        .wr_strb_mask (strb_mask),
        .ctrl_reg     (ctrl_reg)
    );

    // write response one cycle after both halves are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // reads of any alias return the control word; unmapped gives slverr
    assign rd_hit = addr_hit(s_axi_araddr);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_hit ? (ctrl_reg & IMPL_MASK) : 32'h0000_0000; // [R8]
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // analog controls follow the stored word one edge after it changes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ladder_ctrl <= '0; // [R10]
        else
        begin
            ladder_ctrl.enable               <= ctrl_reg[ENABLE_BIT]; // [R1] [R12]
            ladder_ctrl.pin_output_enable    <= ctrl_reg[PIN_OE_BIT]; // [R3]
            ladder_ctrl.range_select         <= ctrl_reg[RANGE_BIT];  // [R4] [R5]
            ladder_ctrl.supply_source_select <= ctrl_reg[SOURCE_BIT]; // [R6]
            ladder_ctrl.tap_value            <= ctrl_reg[3:0];        // [R7]
        end
    end

    // analog controls and the stored word
    a_ctrl_follows: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ladder_ctrl == {$past(ctrl_reg[ENABLE_BIT]), $past(ctrl_reg[6:0])})
        else $error("ladder controls lag the register");

    a_enable_out: assert property ( // [R1]
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ladder_ctrl.enable == $past(ctrl_reg[ENABLE_BIT]))
        else $error("enable output wrong");

    a_pin_oe: assert property ( // [R3]
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ladder_ctrl.pin_output_enable == $past(ctrl_reg[PIN_OE_BIT]))
        else $error("pin enable wrong");

    a_range_out: assert property ( // [R4] [R5]
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ladder_ctrl.range_select == $past(ctrl_reg[RANGE_BIT]))
        else $error("range output wrong");

    a_source_out: assert property ( // [R6]
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ladder_ctrl.supply_source_select == $past(ctrl_reg[SOURCE_BIT]))
        else $error("source output wrong");

    a_tap_out: assert property ( // [R7]
        @(posedge aclk) disable iff (!aresetn)
        1'b1 |=> ladder_ctrl.tap_value == $past(ctrl_reg[3:0]))
        else $error("tap output wrong");

    a_enable_keeps: assert property ( // [R2]
        @(posedge aclk) disable iff (!aresetn)
        $changed(ctrl_reg[ENABLE_BIT]) && ($past(wr_op) != OP_WRITE) &&
        (($past(wdata_reg[6:0]) & $past(strb_mask[6:0])) == 7'h00) |-> $stable(ctrl_reg[6:0]))
        else $error("enable change disturbed fields");

    a_no_write_idle: assert property ( // [R2]
        @(posedge aclk) disable iff (!aresetn)
        !(wr_fire && wr_hit) |=> $stable(ctrl_reg))
        else $error("word changed without a write");

    a_reset_zero: assert property ( // [R10]
        @(posedge aclk)
        !aresetn |=> ladder_ctrl == '0 && ctrl_reg == 32'h0000_0000)
        else $error("reset left state");

    a_read_zero_top: assert property ( // [R8]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[14:7] == 8'h00)
        else $error("reserved read bits nonzero");

    // register bus handshakes
    a_aw_taken: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready |=> aw_held_reg && awaddr_reg == $past(s_axi_awaddr))
        else $error("write address not held");

    a_w_taken: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_wvalid && s_axi_wready |=> w_held_reg && wdata_reg == $past(s_axi_wdata))
        else $error("write data not held");

    a_held_clear: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        wr_fire |=> !aw_held_reg && !w_held_reg)
        else $error("held halves not released");

    a_write_resp: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid)
        else $error("write response missing");

    a_write_busy: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");

    a_bresp_holds: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

    a_bvalid_once: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");

    a_read_answer: assert property ( // [R9]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");

    a_read_busy: assert property ( // [R8]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");

    a_rdata_holds: assert property ( // [R8]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped early");

    a_rvalid_once: assert property ( // [R8]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");

    // decode and write effects
    a_alias_read: assert property ( // [R9]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && rd_hit |=>
        s_axi_rresp == RESP_OKAY && s_axi_rdata == ($past(ctrl_reg) & IMPL_MASK))
        else $error("mapped read wrong");

    a_unmapped_read: assert property ( // [R9]
        @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && !rd_hit |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read wrong");

    a_unmapped_write: assert property ( // [R9]
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && !wr_hit |=> $stable(ctrl_reg) && s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write wrong");

    a_mapped_write: assert property ( // [R9]
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_hit |=> s_axi_bresp == RESP_OKAY)
        else $error("mapped write refused");

    a_full_write: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_hit && wr_op == OP_WRITE && wstrb_reg == 4'hf |=>
        ctrl_reg == ($past(wdata_reg) & IMPL_MASK))
        else $error("full write did not land");

    a_strobe_keep: assert property ( // [R12]
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_hit && wr_op == OP_WRITE && !wstrb_reg[1] |=> $stable(ctrl_reg[15:8]))
        else $error("unstrobed byte changed");
endmodule
`default_nettype wire

// *** ref_ladder_pkg.sv ***
// package for the comparator reference ladder control block
// assumes a single aclk domain and an AXI4-Lite register bus
package ref_ladder_pkg;
    localparam int          ADDR_W         = 16;
    localparam logic [15:0] CTRL_OFFSET    = 16'h9800;
    localparam logic [15:0] CLR_ALIAS      = 16'h0004;
    localparam logic [15:0] SET_ALIAS      = 16'h0008;
    localparam logic [15:0] INV_ALIAS      = 16'h000c;
    localparam int          ENABLE_BIT     = 15;
    localparam int          PIN_OE_BIT     = 6;
    localparam int          RANGE_BIT      = 5;
    localparam int          SOURCE_BIT     = 4;
    localparam logic [31:0] IMPL_MASK      = 32'h0000_807f;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    // low range step is source/24, upper range is source/4 + tap*source/32
    localparam int          LOW_RANGE_DIV  = 24;
    localparam int          HIGH_RANGE_DIV = 32;

    typedef enum logic [1:0]
    {
        OP_WRITE = 2'b00,
        OP_CLEAR = 2'b01,
        OP_SET   = 2'b10,
        OP_INV   = 2'b11
    } write_op_t;

    typedef struct packed
    {
        logic       enable;
        logic       pin_output_enable;
        logic       range_select;
        logic       supply_source_select;
        logic [3:0] tap_value;
    } ladder_ctrl_t;
endpackage

// *** ref_ladder_regfile.sv ***
// control register store with write, clear, set and invert operations
// assumes the bus slave decodes the address and issues one-cycle write pulses
`timescale 1ns/10ps
`default_nettype none
module ref_ladder_regfile
(
    input  wire logic                      aclk,         // bus clock
    input  wire logic                      aresetn,      // synchronous reset, low
    input  wire logic                      wr_en,        // one-cycle write pulse
    input  wire ref_ladder_pkg::write_op_t wr_op,        // which alias was written
    input  wire logic [31:0]               wr_data,      // raw write data
    input  wire logic [31:0]               wr_strb_mask, // per-bit lane mask
    output logic [31:0]                    ctrl_reg      // stored register value
);
    import ref_ladder_pkg::*;

    logic [31:0] ctrl_next;
    logic [31:0] bits;

    always_comb
    begin
        bits = wr_data & wr_strb_mask & IMPL_MASK; // [R8]
        case (wr_op)
            OP_WRITE: ctrl_next = (ctrl_reg & ~(wr_strb_mask & IMPL_MASK)) | bits;
            OP_CLEAR: ctrl_next = ctrl_reg & ~bits; // [R9]
            OP_SET:   ctrl_next = ctrl_reg | bits;  // [R9]
            OP_INV:   ctrl_next = ctrl_reg ^ bits;  // [R9]
            default:  ctrl_next = ctrl_reg;
        endcase
    end

    // clear, set and invert writes change only bits written one; plain writes replace every strobed field
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_reg <= CTRL_RESET; // [R10]
        else if (wr_en)
            ctrl_reg <= ctrl_next; // [R2]
    end

    a_reserved_zero: assert property ( // [R8]
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_reg & ~IMPL_MASK) == 32'h0000_0000)
        else $error("reserved bits set");
    a_clear_alias: assert property ( // [R9]
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_op == OP_CLEAR |=> (ctrl_reg & $past(bits)) == 32'h0000_0000)
        else $error("clear alias left bits set");
    a_set_alias: assert property ( // [R9]
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_op == OP_SET |=> (ctrl_reg & $past(bits)) == $past(bits))
        else $error("set alias missed bits");
    a_inv_alias: assert property ( // [R9]
        @(posedge aclk) disable iff (!aresetn)
        wr_en && wr_op == OP_INV |=> ctrl_reg == ($past(ctrl_reg) ^ $past(bits)))
        else $error("invert alias wrong");
endmodule
`default_nettype wire

// *** comparator_reference_ladder_control_test.sv ***
// testbench for the reference ladder control block: register tests over AXI4-Lite
// assumes ref_ladder_pkg and the design files are compiled first
`timescale 1ns/10ps
`default_nettype none
module comparator_reference_ladder_control_test;
    import ref_ladder_pkg::*;
    logic         aclk;
    logic         aresetn;
    logic [15:0]  s_axi_awaddr;
    logic         s_axi_awvalid;
    logic         s_axi_awready;
    logic [31:0]  s_axi_wdata;
    logic [3:0]   s_axi_wstrb;
    logic         s_axi_wvalid;
    logic         s_axi_wready;
    logic [1:0]   s_axi_bresp;
    logic         s_axi_bvalid;
    logic         s_axi_bready;
    logic [15:0]  s_axi_araddr;
    logic         s_axi_arvalid;
    logic         s_axi_arready;
    logic [31:0]  s_axi_rdata;
    logic [1:0]   s_axi_rresp;
    logic         s_axi_rvalid;
    logic         s_axi_rready;
    ladder_ctrl_t ladder_ctrl;
    int           n_mismatch = 0;
    int           cmp_count = 0;
    int           cyc = 0;
    logic [1:0]   resp;
    logic [31:0]  rd;
    logic [31:0]  v;

    ref_ladder_ctrl ref_ladder_ctrl_i
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .ladder_ctrl(ladder_ctrl)
    );

    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // handshakes are judged at the falling edge, where readies and valids are settled
    task automatic axi_wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic wd;
        logic bd;
        ad = 1'b0;
        wd = 1'b0;
        bd = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ad && wd))
        begin
            @(negedge aclk);
            ad = ad | (s_axi_awvalid & s_axi_awready);
            wd = wd | (s_axi_wvalid & s_axi_wready);
            @(posedge aclk);
            if (ad) s_axi_awvalid <= 1'b0;
            if (wd) s_axi_wvalid <= 1'b0;
        end
        while (!bd)
        begin
            @(negedge aclk);
            bd = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic rv;
        ad = 1'b0;
        rv = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!ad)
        begin
            @(negedge aclk);
            ad = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        while (!rv)
        begin
            @(negedge aclk);
            rv = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
    endtask

    // write, then read back the control word and compare the ladder controls
    task automatic wchk(input logic [15:0] a, input logic [31:0] d, input logic [31:0] exp);
        axi_wr(a, d, resp);
        chk("bresp", {30'h0, resp}, {30'h0, RESP_OKAY});
        axi_rd(CTRL_OFFSET, rd, resp);
        chk("rresp", {30'h0, resp}, {30'h0, RESP_OKAY});
        chk("control word", rd, exp);
        chk("ladder controls", {24'h0, ladder_ctrl}, {24'h0, exp[15], exp[6:0]});
    endtask

    initial
    begin
        aresetn = 1'b0;
        s_axi_awaddr = 16'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 16'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(CTRL_OFFSET, rd, resp);
        chk("reset word", rd, CTRL_RESET);
        chk("reset ladder", {24'h0, ladder_ctrl}, 32'h0);
        $display("test reset done");
        wchk(CTRL_OFFSET, 32'hffff_ffff, 32'h0000_807f);
        wchk(CTRL_OFFSET | CLR_ALIAS, 32'h0000_8000, 32'h0000_007f);
        wchk(CTRL_OFFSET | SET_ALIAS, 32'hffff_8000, 32'h0000_807f);
        wchk(CTRL_OFFSET | INV_ALIAS, 32'h0000_0055, 32'h0000_802a);
        $display("test aliases done");
        for (int t = 0; t < 16; t++)
        begin
            v = {16'h0, t[3], 7'h0, 1'b0, t[2:0], t[3:0]};
            wchk(CTRL_OFFSET, v, v);
        end
        $display("test fields done");
        s_axi_wstrb <= 4'h1;
        wchk(CTRL_OFFSET, 32'h0000_0000, 32'h0000_8000);
        s_axi_wstrb <= 4'h2;
        wchk(CTRL_OFFSET | INV_ALIAS, 32'hffff_ffff, 32'h0000_0000);
        s_axi_wstrb <= 4'hf;
        wchk(CTRL_OFFSET | SET_ALIAS, 32'h0000_807f, 32'h0000_807f);
        $display("test strobes done");
        axi_wr(16'h9810, 32'hffff_ffff, resp);
        chk("unmapped bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_rd(16'h9810, rd, resp);
        chk("unmapped rdata", rd, 32'h0);
        chk("unmapped rresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_rd(CTRL_OFFSET | SET_ALIAS, rd, resp);
        chk("alias read", rd, 32'h0000_807f);
        $display("test unmapped done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(CTRL_OFFSET, rd, resp);
        chk("second reset word", rd, CTRL_RESET);
        chk("second reset ladder", {24'h0, ladder_ctrl}, 32'h0);
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire
